// ==== aipd_param_decoder.sv ====
// Operation
// - Hold sixteen-byte parameter area, two record sets
// - Two-channel variant ignores absent pair fields
// - Record set 0 writes refused during runtime
// - Set 0 byte 0: group diagnosis per pair
// - Set 0 byte 1: wire-break test per pair
// - Set 1 byte 0: diagnostic, process interrupt enables
// - Set 1 byte 1: four two-bit suppression selectors
// - Bytes 2-5: pair range and type nibbles
// - Bytes 6-13: channel 0/2 limit values
// - Mode byte zero deactivates the pair
// - Type 0001b: voltage ranges decoded
// - Bipolar: overdrive 32511, underdrive -32512
// - Unipolar: underdrive -4864, overdrive 32511
// - Type 0010b: four-wire current ranges decoded
// - Type 0011b: two-wire 4-20 mA only
// - Beyond region ends report 7FFFh / 8000h
// - Power-on: 10 V, 50 Hz, diagnostics off
// - 4-20 mA wire break: diagnostic, 8000h, interrupt
`timescale 1ns/1ps
`include "aipd_consts.svh"

module aipd_param_decoder #(
  parameter int unsigned NUM_PAIRS = 4,
  parameter int unsigned T400HZ_CYC = `AIPD_T400HZ_US * `AIPD_CLK_MHZ,
  parameter int unsigned T60HZ_CYC = `AIPD_T60HZ_US * `AIPD_CLK_MHZ,
  parameter int unsigned T50HZ_CYC = `AIPD_T50HZ_US * `AIPD_CLK_MHZ,
  parameter int unsigned T10HZ_CYC = `AIPD_T10HZ_US * `AIPD_CLK_MHZ
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic run_mode_in,
  input wire logic rec_wr_in,
  input wire logic rec_rd_in,
  input wire logic rec_set_in,
  input wire logic [3:0] rec_addr_in,
  input wire logic [7:0] rec_wdata_in,
  output logic [7:0] rec_rdata_out,
  output logic rec_reject_out,
  input wire logic sample_vld_in,
  input wire logic [2:0] sample_ch_in,
  input wire logic [17:0] sample_raw_in,
  input wire logic sample_low_in,
  output logic [3:0] conv_start_out,
  output logic [3:0] pair_active_out,
  output logic [15:0] value_out,
  output logic value_vld_out,
  output logic [2:0] value_ch_out,
  output logic diag_evt_out,
  output logic diag_irq_out,
  output logic proc_irq_out
);

  aipd_pkg::aipd_state_t s_q;
  aipd_pkg::aipd_state_t s_d;

  logic [3:0] pair_present;
  aipd_pkg::aipd_class_t pair_cls [4];
  logic [3:0] pair_4to20;

  function automatic aipd_pkg::aipd_class_t mode_class(input logic [7:0] m);
    aipd_pkg::aipd_class_t c;
    c = aipd_pkg::AIPD_CLS_OFF;
    case (m[7:4])
      `AIPD_TYPE_VOLT: begin
        if (m[3:0] == `AIPD_RNG_80MV || m[3:0] == `AIPD_RNG_250MV || m[3:0] == `AIPD_RNG_500MV ||
            m[3:0] == `AIPD_RNG_1V || m[3:0] == `AIPD_RNG_2V5 || m[3:0] == `AIPD_RNG_5V ||
            m[3:0] == `AIPD_RNG_10V) begin
          c = aipd_pkg::AIPD_CLS_BIPOLAR;
        end else if (m[3:0] == `AIPD_RNG_1TO5V) begin
          c = aipd_pkg::AIPD_CLS_UNIPOLAR;
        end
      end
      `AIPD_TYPE_CUR4: begin
        if (m[3:0] == `AIPD_RNG_3M2A || m[3:0] == `AIPD_RNG_10MA || m[3:0] == `AIPD_RNG_20MA) begin
          c = aipd_pkg::AIPD_CLS_BIPOLAR;
        end else if (m[3:0] == `AIPD_RNG_0TO20MA || m[3:0] == `AIPD_RNG_4TO20MA) begin
          c = aipd_pkg::AIPD_CLS_UNIPOLAR;
        end
      end
      `AIPD_TYPE_CUR2: begin
        if (m[3:0] == `AIPD_RNG_4TO20MA) begin
          c = aipd_pkg::AIPD_CLS_UNIPOLAR;
        end
      end
      default: begin
        c = aipd_pkg::AIPD_CLS_OFF;
      end
    endcase
    return c;
  endfunction

  function automatic logic [23:0] integ_cycles(input logic [1:0] sel);
    logic [23:0] n;
    n = 24'(T50HZ_CYC);
    case (aipd_pkg::aipd_supp_t'(sel))
      aipd_pkg::AIPD_SUP_400HZ: n = 24'(T400HZ_CYC);
      aipd_pkg::AIPD_SUP_60HZ: n = 24'(T60HZ_CYC);
      aipd_pkg::AIPD_SUP_50HZ: n = 24'(T50HZ_CYC);
      default: n = 24'(T10HZ_CYC);
    endcase
    return n;
  endfunction

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_pair
      assign pair_present[gp] = (gp < NUM_PAIRS);
      assign pair_cls[gp] = pair_present[gp] ? mode_class(s_q.mode[gp]) : aipd_pkg::AIPD_CLS_OFF;
      assign pair_4to20[gp] = (s_q.mode[gp][3:0] == `AIPD_RNG_4TO20MA) &&
                              ((s_q.mode[gp][7:4] == `AIPD_TYPE_CUR4) || (s_q.mode[gp][7:4] == `AIPD_TYPE_CUR2));
      assign pair_active_out[gp] = (pair_cls[gp] != aipd_pkg::AIPD_CLS_OFF);
    end
  endgenerate

  always_comb begin
    logic [1:0] sp;
    logic [17:0] und_end;
    logic [15:0] v;
    logic ovr;
    logic und;
    logic wb;
    logic lim;
    sp = 2'b00;
    und_end = `AIPD_BI_UND_END;
    v = 16'h0000;
    ovr = 1'b0;
    und = 1'b0;
    wb = 1'b0;
    lim = 1'b0;
    s_d = s_q;
    s_d.reject = 1'b0;
    s_d.value_vld = 1'b0;
    s_d.diag_evt = 1'b0;
    s_d.diag_irq = 1'b0;
    s_d.proc_irq = 1'b0;
    s_d.conv_start = 4'h0;

    // Set 0 is frozen while running, set 1 may change at any time
    // Limit halves land one byte at a time, no atomic pair update
    if (rec_wr_in) begin
      if (!rec_set_in) begin
        if (run_mode_in) begin
          s_d.reject = 1'b1;
        end else if (rec_addr_in == `AIPD_GROUP_DIAG_ENABLE_OFS) begin
          s_d.gdiag = rec_wdata_in & `AIPD_PAIR_EN_MASK;
        end else if (rec_addr_in == `AIPD_WIRE_BREAK_ENABLE_OFS) begin
          s_d.wbrk = rec_wdata_in & `AIPD_PAIR_EN_MASK;
        end
      end else begin
        if (rec_addr_in == `AIPD_INTERRUPT_ENABLE_OFS) begin
          s_d.irqen = rec_wdata_in & `AIPD_IRQ_EN_MASK;
        end else if (rec_addr_in == `AIPD_SUPPRESSION_SELECT_OFS) begin
          s_d.supp = rec_wdata_in;
        end else if (rec_addr_in == `AIPD_PAIR01_MODE_OFS) begin
          s_d.mode[0] = rec_wdata_in;
        end else if (rec_addr_in == `AIPD_PAIR23_MODE_OFS) begin
          s_d.mode[1] = rec_wdata_in;
        end else if (rec_addr_in == `AIPD_PAIR45_MODE_OFS) begin
          s_d.mode[2] = rec_wdata_in;
        end else if (rec_addr_in == `AIPD_PAIR67_MODE_OFS) begin
          s_d.mode[3] = rec_wdata_in;
        end else if (rec_addr_in == `AIPD_CH0_UPPER_LIMIT_OFS) begin
          s_d.ch0_up[15:8] = rec_wdata_in;
        end else if (rec_addr_in == `AIPD_CH0_UPPER_LIMIT_OFS + 4'h1) begin
          s_d.ch0_up[7:0] = rec_wdata_in;
        end else if (rec_addr_in == `AIPD_CH0_LOWER_LIMIT_OFS) begin
          s_d.ch0_lo[15:8] = rec_wdata_in;
        end else if (rec_addr_in == `AIPD_CH0_LOWER_LIMIT_OFS + 4'h1) begin
          s_d.ch0_lo[7:0] = rec_wdata_in;
        end else if (rec_addr_in == `AIPD_CH2_UPPER_LIMIT_OFS) begin
          s_d.ch2_up[15:8] = rec_wdata_in;
        end else if (rec_addr_in == `AIPD_CH2_UPPER_LIMIT_OFS + 4'h1) begin
          s_d.ch2_up[7:0] = rec_wdata_in;
        end else if (rec_addr_in == `AIPD_CH2_LOWER_LIMIT_OFS) begin
          s_d.ch2_lo[15:8] = rec_wdata_in;
        end else if (rec_addr_in == `AIPD_CH2_LOWER_LIMIT_OFS + 4'h1) begin
          s_d.ch2_lo[7:0] = rec_wdata_in;
        end
      end
    end

    // Read back of the stored area, unused bytes read zero
    if (rec_rd_in) begin
      s_d.rd_data = 8'h00;
      if (!rec_set_in) begin
        if (rec_addr_in == `AIPD_GROUP_DIAG_ENABLE_OFS) begin
          s_d.rd_data = s_q.gdiag;
        end else if (rec_addr_in == `AIPD_WIRE_BREAK_ENABLE_OFS) begin
          s_d.rd_data = s_q.wbrk;
        end
      end else begin
        if (rec_addr_in == `AIPD_INTERRUPT_ENABLE_OFS) begin
          s_d.rd_data = s_q.irqen;
        end else if (rec_addr_in == `AIPD_SUPPRESSION_SELECT_OFS) begin
          s_d.rd_data = s_q.supp;
        end else if (rec_addr_in >= `AIPD_PAIR01_MODE_OFS && rec_addr_in <= `AIPD_PAIR67_MODE_OFS) begin
          s_d.rd_data = s_q.mode[2'(rec_addr_in - `AIPD_PAIR01_MODE_OFS)];
        end else if (rec_addr_in == `AIPD_CH0_UPPER_LIMIT_OFS) begin
          s_d.rd_data = s_q.ch0_up[15:8];
        end else if (rec_addr_in == `AIPD_CH0_UPPER_LIMIT_OFS + 4'h1) begin
          s_d.rd_data = s_q.ch0_up[7:0];
        end else if (rec_addr_in == `AIPD_CH0_LOWER_LIMIT_OFS) begin
          s_d.rd_data = s_q.ch0_lo[15:8];
        end else if (rec_addr_in == `AIPD_CH0_LOWER_LIMIT_OFS + 4'h1) begin
          s_d.rd_data = s_q.ch0_lo[7:0];
        end else if (rec_addr_in == `AIPD_CH2_UPPER_LIMIT_OFS) begin
          s_d.rd_data = s_q.ch2_up[15:8];
        end else if (rec_addr_in == `AIPD_CH2_UPPER_LIMIT_OFS + 4'h1) begin
          s_d.rd_data = s_q.ch2_up[7:0];
        end else if (rec_addr_in == `AIPD_CH2_LOWER_LIMIT_OFS) begin
          s_d.rd_data = s_q.ch2_lo[15:8];
        end else if (rec_addr_in == `AIPD_CH2_LOWER_LIMIT_OFS + 4'h1) begin
          s_d.rd_data = s_q.ch2_lo[7:0];
        end
      end
    end

    // Conversion pacing per active pair
    for (int i = 0; i < 4; i++) begin
      if (pair_cls[i] == aipd_pkg::AIPD_CLS_OFF) begin
        s_d.tmr[i] = 24'h000000;
      end else if (s_q.tmr[i] == 24'h000000) begin
        s_d.tmr[i] = integ_cycles(s_q.supp[2*i +: 2]) - 24'h000001;
        s_d.conv_start[i] = 1'b1;
      end else begin
        s_d.tmr[i] = s_q.tmr[i] - 24'h000001;
      end
    end

    // Clamp first, so the limit check sees the reported value
    // Wire break overrides any in-range reading
    if (sample_vld_in) begin
      sp = sample_ch_in[2:1];
      if (pair_cls[sp] != aipd_pkg::AIPD_CLS_OFF) begin
        if (pair_cls[sp] == aipd_pkg::AIPD_CLS_UNIPOLAR) begin
          und_end = `AIPD_UNI_UND_END;
        end
        ovr = $signed(sample_raw_in) > $signed(`AIPD_OVR_END);
        und = $signed(sample_raw_in) < $signed(und_end);
        wb = pair_4to20[sp] && s_q.wbrk[sp] && sample_low_in;
        if (wb || und) begin
          v = `AIPD_VAL_UNDER;
        end else if (ovr) begin
          v = `AIPD_VAL_OVER;
        end else begin
          v = sample_raw_in[15:0];
        end
        s_d.value = v;
        s_d.value_ch = sample_ch_in;
        s_d.value_vld = 1'b1;
        s_d.diag_evt = wb || (s_q.gdiag[sp] && (ovr || und));
        s_d.diag_irq = s_d.diag_evt && s_q.irqen[`AIPD_DIAG_IRQ_BIT];
        if (sample_ch_in == 3'h0) begin
          lim = $signed(v) > $signed(s_q.ch0_up) || $signed(v) < $signed(s_q.ch0_lo);
        end else if (sample_ch_in == 3'h2) begin
          lim = $signed(v) > $signed(s_q.ch2_up) || $signed(v) < $signed(s_q.ch2_lo);
        end
        s_d.proc_irq = lim && s_q.irqen[`AIPD_PROC_IRQ_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
      s_q.gdiag <= `AIPD_GROUP_DIAG_RST;
      s_q.wbrk <= `AIPD_WIRE_BREAK_RST;
      s_q.irqen <= `AIPD_IRQ_EN_RST;
      s_q.supp <= `AIPD_SUPP_RST;
      s_q.mode <= {4{`AIPD_MODE_RST}};
      s_q.ch0_up <= `AIPD_UPPER_RST;
      s_q.ch0_lo <= `AIPD_LOWER_RST;
      s_q.ch2_up <= `AIPD_UPPER_RST;
      s_q.ch2_lo <= `AIPD_LOWER_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rec_rdata_out = s_q.rd_data;
  assign rec_reject_out = s_q.reject;
  assign conv_start_out = s_q.conv_start;
  assign value_out = s_q.value;
  assign value_vld_out = s_q.value_vld;
  assign value_ch_out = s_q.value_ch;
  assign diag_evt_out = s_q.diag_evt;
  assign diag_irq_out = s_q.diag_irq;
  assign proc_irq_out = s_q.proc_irq;

endmodule

// ==== aipd_consts.svh ====
`ifndef AIPD_CONSTS_SVH
`define AIPD_CONSTS_SVH

`define AIPD_CLK_MHZ 100

// Record set 0 byte offsets
`define AIPD_GROUP_DIAG_ENABLE_OFS 4'h0
`define AIPD_WIRE_BREAK_ENABLE_OFS 4'h1
// Record set 1 byte offsets
`define AIPD_INTERRUPT_ENABLE_OFS 4'h0
`define AIPD_SUPPRESSION_SELECT_OFS 4'h1
`define AIPD_PAIR01_MODE_OFS 4'h2
`define AIPD_PAIR23_MODE_OFS 4'h3
`define AIPD_PAIR45_MODE_OFS 4'h4
`define AIPD_PAIR67_MODE_OFS 4'h5
`define AIPD_CH0_UPPER_LIMIT_OFS 4'h6
`define AIPD_CH0_LOWER_LIMIT_OFS 4'h8
`define AIPD_CH2_UPPER_LIMIT_OFS 4'hA
`define AIPD_CH2_LOWER_LIMIT_OFS 4'hC

// Field layout
`define AIPD_PAIR_EN_MASK 8'h0F
`define AIPD_IRQ_EN_MASK 8'hC0
`define AIPD_DIAG_IRQ_BIT 6
`define AIPD_PROC_IRQ_BIT 7

// Reset values
`define AIPD_GROUP_DIAG_RST 8'h00
`define AIPD_WIRE_BREAK_RST 8'h00
`define AIPD_IRQ_EN_RST 8'h00
`define AIPD_SUPP_RST 8'hAA
`define AIPD_MODE_RST 8'h19
`define AIPD_UPPER_RST 16'h7FFF
`define AIPD_LOWER_RST 16'h8000

// Measuring types
`define AIPD_TYPE_VOLT 4'h1
`define AIPD_TYPE_CUR4 4'h2
`define AIPD_TYPE_CUR2 4'h3
// Range codes
`define AIPD_RNG_80MV 4'h1
`define AIPD_RNG_250MV 4'h2
`define AIPD_RNG_500MV 4'h3
`define AIPD_RNG_1V 4'h4
`define AIPD_RNG_2V5 4'h5
`define AIPD_RNG_5V 4'h6
`define AIPD_RNG_1TO5V 4'h7
`define AIPD_RNG_10V 4'h9
`define AIPD_RNG_3M2A 4'h0
`define AIPD_RNG_10MA 4'h1
`define AIPD_RNG_20MA 4'h4
`define AIPD_RNG_0TO20MA 4'h2
`define AIPD_RNG_4TO20MA 4'h3

// Scaled value limits, 18-bit two's complement, and 16-bit reported end values
`define AIPD_OVR_END 18'h07EFF
`define AIPD_BI_UND_END 18'h38100
`define AIPD_UNI_UND_END 18'h3ED00
`define AIPD_VAL_OVER 16'h7FFF
`define AIPD_VAL_UNDER 16'h8000

// Integration times in microseconds
`define AIPD_T400HZ_US 2500
`define AIPD_T60HZ_US 16600
`define AIPD_T50HZ_US 20000
`define AIPD_T10HZ_US 100000

`endif

// ==== aipd_pkg.sv ====
package aipd_pkg;

  typedef enum logic [1:0] {
    AIPD_CLS_OFF = 2'b00,
    AIPD_CLS_BIPOLAR = 2'b01,
    AIPD_CLS_UNIPOLAR = 2'b10
  } aipd_class_t;

  typedef enum logic [1:0] {
    AIPD_SUP_400HZ = 2'b00,
    AIPD_SUP_60HZ = 2'b01,
    AIPD_SUP_50HZ = 2'b10,
    AIPD_SUP_10HZ = 2'b11
  } aipd_supp_t;

  typedef struct packed {
    logic [7:0] gdiag;
    logic [7:0] wbrk;
    logic [7:0] irqen;
    logic [7:0] supp;
    logic [3:0][7:0] mode;
    logic [15:0] ch0_up;
    logic [15:0] ch0_lo;
    logic [15:0] ch2_up;
    logic [15:0] ch2_lo;
    logic [3:0][23:0] tmr;
    logic [3:0] conv_start;
    logic [15:0] value;
    logic value_vld;
    logic [2:0] value_ch;
    logic diag_evt;
    logic diag_irq;
    logic proc_irq;
    logic reject;
    logic [7:0] rd_data;
  } aipd_state_t;

endpackage

// ==== aipd_props.sv ====
`timescale 1ns/1ps
module aipd_props (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic run_mode_in,
  input wire logic rec_wr_in,
  input wire logic rec_set_in,
  input wire logic rec_reject_out,
  input wire logic sample_vld_in,
  input wire logic [2:0] sample_ch_in,
  input wire logic [17:0] sample_raw_in,
  input wire logic sample_low_in,
  input wire logic [3:0] pair_active_out,
  input wire logic [15:0] value_out,
  input wire logic value_vld_out,
  input wire logic [2:0] value_ch_out,
  input wire logic diag_evt_out,
  input wire logic diag_irq_out,
  input wire logic proc_irq_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic rej;
  logic tk;
  logic ok;
  int r;
  assign rej = rec_wr_in && !rec_set_in && run_mode_in;
  assign tk = sample_vld_in && pair_active_out[sample_ch_in[2:1]];
  assign ok = tk && !sample_low_in;
  assign r = int'($signed(sample_raw_in));
  property p_rej; rej |=> rec_reject_out; endproperty
  property p_norej; !rej |=> !rec_reject_out; endproperty
  property p_val; tk |=> value_vld_out && value_ch_out == $past(sample_ch_in); endproperty
  property p_idle; !tk |=> !value_vld_out; endproperty
  property p_ovr; ok && r > 32511 |=> value_out == 16'h7FFF; endproperty
  property p_und; ok && r < -32512 |=> value_out == 16'h8000; endproperty
  property p_mid; ok && r >= -4864 && r <= 32511 |=> value_out == $past(sample_raw_in[15:0]); endproperty
  property p_dirq; diag_irq_out |-> diag_evt_out; endproperty
  property p_proc; proc_irq_out |-> value_vld_out && (value_ch_out == 3'h0 || value_ch_out == 3'h2); endproperty
  a_rej: assert property (p_rej) else $error("set 0 write in run not refused");
  a_norej: assert property (p_norej) else $error("spurious refusal");
  a_val: assert property (p_val) else $error("sample on active pair not answered");
  a_idle: assert property (p_idle) else $error("value without active sample");
  a_ovr: assert property (p_ovr) else $error("overflow not clamped");
  a_und: assert property (p_und) else $error("underflow not clamped");
  a_mid: assert property (p_mid) else $error("in-range value altered");
  a_dirq: assert property (p_dirq) else $error("diag interrupt without event");
  a_proc: assert property (p_proc) else $error("limit interrupt on wrong channel");
  c_rej: cover property (rec_reject_out);
  c_dirq: cover property (diag_irq_out);
  c_proc: cover property (proc_irq_out);
endmodule
bind aipd_param_decoder aipd_props u_props (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
  .run_mode_in(run_mode_in), .rec_wr_in(rec_wr_in), .rec_set_in(rec_set_in),
  .rec_reject_out(rec_reject_out), .sample_vld_in(sample_vld_in), .sample_ch_in(sample_ch_in),
  .sample_raw_in(sample_raw_in), .sample_low_in(sample_low_in), .pair_active_out(pair_active_out),
  .value_out(value_out), .value_vld_out(value_vld_out), .value_ch_out(value_ch_out),
  .diag_evt_out(diag_evt_out), .diag_irq_out(diag_irq_out), .proc_irq_out(proc_irq_out));

// ==== aipd_cpu_model.sv ====
`timescale 1ns/1ps
module aipd_cpu_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic wr_out,
  output logic rd_out,
  output logic set_out,
  output logic [3:0] addr_out,
  output logic [7:0] wdata_out
);
  initial begin
    wr_out = 1'h0;
    rd_out = 1'h0;
    set_out = 1'h1;
    addr_out = 4'h0;
    wdata_out = 8'h00;
  end
  // Held from falling edge across the taking rising edge
  task automatic wr(input logic s, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_out = 1'h1;
    set_out = s;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    wr_out = 1'h0;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic s, input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_in);
    rd_out = 1'h1;
    set_out = s;
    addr_out = a;
    @(negedge clk_in);
    rd_out = 1'h0;
    d = rdata_in;
  endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_in, rst_b_in, run_mode_in, sample_vld_in, sample_low_in;
  logic rec_wr_in, rec_rd_in, rec_set_in, rec_reject_out;
  logic value_vld_out, diag_evt_out, diag_irq_out, proc_irq_out, vld2;
  logic [3:0] rec_addr_in, conv_start_out, pair_active_out, act2;
  logic [7:0] rec_wdata_in, rec_rdata_out, rd;
  logic [2:0] sample_ch_in, value_ch_out;
  logic [17:0] sample_raw_in;
  logic [15:0] value_out;
  logic [31:0] x = 32'h1C04;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  int bnd [8] = '{32511, 32512, -32512, -32513, -4864, -4865, 0, 27648};
  logic [7:0] codes [20] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h19, 8'h20, 8'h21,
    8'h22, 8'h23, 8'h24, 8'h33, 8'h00, 8'h18, 8'h25, 8'h34, 8'h41, 8'h1A};

  aipd_param_decoder #(.T400HZ_CYC(8), .T60HZ_CYC(12), .T50HZ_CYC(16), .T10HZ_CYC(20)) dut (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .run_mode_in(run_mode_in), .rec_wr_in(rec_wr_in),
    .rec_rd_in(rec_rd_in), .rec_set_in(rec_set_in), .rec_addr_in(rec_addr_in), .rec_wdata_in(rec_wdata_in),
    .rec_rdata_out(rec_rdata_out), .rec_reject_out(rec_reject_out), .sample_vld_in(sample_vld_in),
    .sample_ch_in(sample_ch_in), .sample_raw_in(sample_raw_in), .sample_low_in(sample_low_in),
    .conv_start_out(conv_start_out), .pair_active_out(pair_active_out), .value_out(value_out),
    .value_vld_out(value_vld_out), .value_ch_out(value_ch_out), .diag_evt_out(diag_evt_out),
    .diag_irq_out(diag_irq_out), .proc_irq_out(proc_irq_out));
  // Two-channel variant on the same stimulus
  aipd_param_decoder #(.NUM_PAIRS(1), .T400HZ_CYC(8), .T60HZ_CYC(12), .T50HZ_CYC(16), .T10HZ_CYC(20)) dut_two (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .run_mode_in(run_mode_in), .rec_wr_in(rec_wr_in),
    .rec_rd_in(rec_rd_in), .rec_set_in(rec_set_in), .rec_addr_in(rec_addr_in), .rec_wdata_in(rec_wdata_in),
    .rec_rdata_out(), .rec_reject_out(), .sample_vld_in(sample_vld_in),
    .sample_ch_in(sample_ch_in), .sample_raw_in(sample_raw_in), .sample_low_in(sample_low_in),
    .conv_start_out(), .pair_active_out(act2), .value_out(),
    .value_vld_out(vld2), .value_ch_out(), .diag_evt_out(),
    .diag_irq_out(), .proc_irq_out());
  aipd_cpu_model cpu (.clk_in(sys_clk_in), .rdata_in(rec_rdata_out), .wr_out(rec_wr_in),
    .rd_out(rec_rd_in), .set_out(rec_set_in), .addr_out(rec_addr_in), .wdata_out(rec_wdata_in));

  initial begin
    sys_clk_in = 1'h0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic logic [7:0] exp_rst(logic s, logic [3:0] a);
    if (!s) return 8'h00;
    case (a)
      4'h1: return 8'hAA;
      4'h2, 4'h3, 4'h4, 4'h5: return 8'h19;
      4'h6, 4'hA: return 8'h7F;
      4'h7, 4'hB: return 8'hFF;
      4'h8, 4'hC: return 8'h80;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic exp_act(logic [7:0] m);
    return m inside {8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h19, 8'h20, 8'h21, 8'h22,
      8'h23, 8'h24, 8'h33};
  endfunction

  function automatic logic [15:0] exp_val(logic uni, int r);
    if (r > 32511) return 16'h7FFF;
    if (r < (uni ? -4864 : -32512)) return 16'h8000;
    return r[15:0];
  endfunction

  task results();
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task rchk(logic s, logic [3:0] a, logic [7:0] e);
    cpu.rd(s, a, rd);
    chk(16'(rd), 16'(e));
  endtask

  // Pair 2 is kept off, pairs 1 and 3 unipolar
  task smp(logic [2:0] ch, int r, logic low);
    logic [1:0] p;
    p = ch[2:1];
    @(negedge sys_clk_in);
    sample_vld_in = 1'h1;
    sample_ch_in = ch;
    sample_raw_in = r[17:0];
    sample_low_in = low;
    @(negedge sys_clk_in);
    sample_vld_in = 1'h0;
    sample_raw_in = ~sample_raw_in;
    chk(16'(value_vld_out), 16'(p != 2'h2));
    chk(16'(vld2), 16'(p == 2'h0));
    if (p != 2'h2) chk(value_out, (low && p == 2'h3) ? 16'h8000 : exp_val(p[0], r));
    if (p != 2'h2) chk(16'(value_ch_out), 16'(ch));
  endtask

  task per();
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (!conv_start_out[0] && n < 100);
  endtask

  task do_reset();
    rst_b_in = 1'h0;
    repeat (12) @(negedge sys_clk_in);
    rst_b_in = 1'h1;
    chk(16'(pair_active_out), 16'hF);
    chk(16'(act2), 16'h1);
    for (int s = 0; s < 2; s++)
      for (int a = 0; a < 16; a++) rchk(s[0], a[3:0], exp_rst(s[0], a[3:0]));
  endtask

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    run_mode_in = 1'h0;
    sample_vld_in = 1'h0;
    sample_ch_in = 3'h0;
    sample_raw_in = 18'h00000;
    sample_low_in = 1'h0;
    do_reset();
    cpu.wr(1'h0, 4'h0, 8'hFF);
    rchk(1'h0, 4'h0, 8'h0F);
    cpu.wr(1'h0, 4'h1, 8'hFF);
    rchk(1'h0, 4'h1, 8'h0F);
    cpu.wr(1'h1, 4'h0, 8'hFF);
    rchk(1'h1, 4'h0, 8'hC0);
    for (int i = 0; i < 12; i++) begin
      rd = 8'(rnd());
      cpu.wr(1'h1, 4'(6 + i % 8), rd);
      rchk(1'h1, 4'(6 + i % 8), rd);
    end
    run_mode_in = 1'h1;
    cpu.wr(1'h0, 4'h0, 8'h00);
    chk(16'(rec_reject_out), 16'h1);
    rchk(1'h0, 4'h0, 8'h0F);
    foreach (codes[i]) begin
      cpu.wr(1'h1, 4'h2, codes[i]);
      chk(16'(rec_reject_out), 16'h0);
      chk(16'(pair_active_out[0]), 16'(exp_act(codes[i])));
    end
    cpu.wr(1'h1, 4'h2, 8'h19);
    cpu.wr(1'h1, 4'h3, 8'h17);
    cpu.wr(1'h1, 4'h4, 8'h00);
    cpu.wr(1'h1, 4'h5, 8'h33);
    rchk(1'h1, 4'h5, 8'h33);
    foreach (bnd[i]) begin
      smp(3'h0, bnd[i], 1'h0);
      smp(3'h3, bnd[i], 1'h0);
    end
    for (int i = 0; i < 24; i++) smp(3'(rnd()), int'(rnd() % 80000) - 40000, 1'h0);
    smp(3'h6, 100, 1'h1);
    chk(16'(diag_evt_out), 16'h1);
    chk(16'(diag_irq_out), 16'h1);
    smp(3'h3, 100, 1'h1);
    chk(16'(diag_evt_out), 16'h0);
    cpu.wr(1'h1, 4'h0, 8'h00);
    smp(3'h7, 100, 1'h1);
    chk(16'(diag_evt_out), 16'h1);
    chk(16'(diag_irq_out), 16'h0);
    cpu.wr(1'h1, 4'h6, 8'h01);
    cpu.wr(1'h1, 4'h7, 8'h00);
    cpu.wr(1'h1, 4'h8, 8'h00);
    cpu.wr(1'h1, 4'h9, 8'h00);
    cpu.wr(1'h1, 4'h0, 8'h80);
    smp(3'h0, 'h200, 1'h0);
    chk(16'(proc_irq_out), 16'h1);
    smp(3'h1, 'h200, 1'h0);
    chk(16'(proc_irq_out), 16'h0);
    smp(3'h0, -5, 1'h0);
    chk(16'(proc_irq_out), 16'h1);
    for (int s = 0; s < 4; s++) begin
      cpu.wr(1'h1, 4'h1, 8'(s));
      rchk(1'h1, 4'h1, 8'(s));
      per();
      per();
      per();
      chk(16'(n), 16'(8 + 4 * s));
    end
    do_reset();
    results();
  end
endmodule
